// ### hdl/mio_defs.vh
// Constants for the motion I/O function map block.
// Assumes one 20 MHz APB clock domain; included by bare name.
`ifndef MIO_DEFS_VH
`define MIO_DEFS_VH
// ====================================================================
// Register offsets
`define MIO_OFS_FUNC     12'h000
`define MIO_OFS_OUT      12'h004
`define MIO_OFS_IN       12'h008
`define MIO_OFS_STAT     12'h00C
`define MIO_OFS_MASK     12'h010
`define MIO_OFS_CMD      12'h014
`define MIO_OFS_BRAKE    12'h018
`define MIO_OFS_INWORD   12'h01C
`define MIO_OFS_CTRL     12'h020
// ====================================================================
// Function register fields
`define MIO_F_AN0        0
`define MIO_F_AN1        1
`define MIO_F_PLIM       2
`define MIO_F_NLIM       3
`define MIO_F_IDX4       4
`define MIO_F_IDX5       5
`define MIO_F_GO6        6
`define MIO_F_HOME6      7
`define MIO_F_NFLT9      8
`define MIO_FUNC_W       9
`define MIO_FUNC_RST     9'h00C
// ====================================================================
// Command register codes
`define MIO_CMD_W        8
`define MIO_CMD_GEN2     8'h02
`define MIO_CMD_GEN3     8'h03
`define MIO_CMD_GENW0    8'h10
`define MIO_CMD_RESTP    8'h20
// ====================================================================
// Brake assignment values
`define MIO_BRK_ON       8'h08
`define MIO_BRK_OFF      8'hFF
// ====================================================================
// Status bits
`define MIO_ST_PLIM      0
`define MIO_ST_NLIM      1
`define MIO_ST_ENLOST    2
`define MIO_ST_BADCMD    3
`define MIO_ST_IDX4      4
`define MIO_ST_IDX5      5
`define MIO_ST_NETERR    6
`define MIO_ST_GO        7
`define MIO_ST_W         8
// ====================================================================
// Misc
`define MIO_NPTS         10
`define MIO_LOWMASK      4'hF
`define MIO_OUT_RST      10'h000
`endif

// ### hdl/mio_edge.v
// Rising edge detector for one synchronous input.
// Assumes the input is already synchronous to pclk.
`timescale 1ns/1ns
module mio_edge (
    pclk,
    presetn,
    din,
    rise
);
    input  wire pclk;
    input  wire presetn;
    input  wire din;
    output wire rise;
    reg         prev_reg;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_reg <= 1'b0;
        end else begin
            prev_reg <= din;
        end
    end
    assign rise = din & ~prev_reg;
endmodule

// ### hdl/mio_sticky.v
// One sticky status bit, write-one-to-clear; set beats clear.
// Assumes single clock domain with async active-low reset.
`timescale 1ns/1ns
module mio_sticky (
    pclk,
    presetn,
    set,
    clr,
    q
);
    input  wire pclk;
    input  wire presetn;
    input  wire set;
    input  wire clr;
    output reg  q;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= 1'b0;
        end else if (set) begin
            q <= 1'b1;
        end else if (clr) begin
            q <= 1'b0;
        end
    end
endmodule

// ### hdl/mio_top.v
// Motion I/O function map: ten logical points, APB register access.
// Assumes synchronous inputs on pclk, an APB master, async reset.
`timescale 1ns/1ns
`include "mio_defs.vh"
module mio_top (
    pclk,
    presetn,
    psel,
    penable,
    pwrite,
    paddr,
    pwdata,
    prdata,
    pready,
    pslverr,
    pin_in,
    bidir_present,
    net_error,
    fault_active,
    brake_request,
    pin_out,
    pin_oe,
    motion_allowed,
    limit_pos,
    limit_neg,
    index_ext,
    index_int,
    go_trigger,
    home_input,
    analog_sel,
    irq
);
    input  wire        pclk;
    input  wire        presetn;
    input  wire        psel;
    input  wire        penable;
    input  wire        pwrite;
    input  wire [11:0] paddr;
    input  wire [31:0] pwdata;
    output reg  [31:0] prdata;
    output reg         pready;
    output reg         pslverr;
    input  wire [9:0]  pin_in;
    input  wire        bidir_present;
    input  wire        net_error;
    input  wire        fault_active;
    input  wire        brake_request;
    output reg  [9:0]  pin_out;
    output reg  [9:0]  pin_oe;
    output reg         motion_allowed;
    output reg         limit_pos;
    output reg         limit_neg;
    output reg         index_ext;
    output reg         index_int;
    output reg         go_trigger;
    output reg         home_input;
    output reg  [1:0]  analog_sel;
    output reg         irq;

    reg  [`MIO_FUNC_W-1:0] func_reg;
    reg  [`MIO_FUNC_W-1:0] func_next;
    reg  [9:0]             gpo_reg;
    reg                    brake_en_reg;
    reg  [`MIO_ST_W-1:0]   mask_reg;
    wire [`MIO_ST_W-1:0]   stat;
    reg  [`MIO_ST_W-1:0]   stat_set;
    reg  [`MIO_ST_W-1:0]   stat_clr;
    reg  [31:0]            rdata_next;
    reg                    err_next;
    wire                   wr_en;
    wire                   bidir_ok;
    wire [4:0]             rises;
    wire                   en_fall;
    reg                    en_prev_reg;
    wire                   cmd_wr;
    wire                   brk_wr;
    wire [`MIO_CMD_W-1:0]  cmd;

    // ================================================================
    // APB decode; zero wait states, one access phase
    // Write lands only on the access edge that sees pready high
    assign wr_en  = psel & penable & pwrite & pready;
    assign cmd    = pwdata[`MIO_CMD_W-1:0];
    assign cmd_wr = wr_en & (paddr == `MIO_OFS_CMD);
    assign brk_wr = wr_en & (paddr == `MIO_OFS_BRAKE);
    assign bidir_ok = bidir_present;

    // ================================================================
    // Function map and commands
    always @* begin
        func_next = func_reg;
        if (wr_en && paddr == `MIO_OFS_FUNC) begin
            func_next = pwdata[`MIO_FUNC_W-1:0];
        end
        if (cmd_wr) begin
            case (cmd)
                `MIO_CMD_GEN2: func_next[`MIO_F_PLIM] = 1'b0;
                `MIO_CMD_GEN3: func_next[`MIO_F_NLIM] = 1'b0;
                `MIO_CMD_GENW0: func_next = {`MIO_FUNC_W{1'b0}};
                `MIO_CMD_RESTP: func_next[`MIO_F_PLIM] = 1'b1;
                default: func_next = func_next;
            endcase
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            func_reg     <= `MIO_FUNC_RST;
            gpo_reg      <= `MIO_OUT_RST;
            brake_en_reg <= 1'b1;
            mask_reg     <= {`MIO_ST_W{1'b0}};
        end else begin
            func_reg <= func_next;
            if (wr_en && paddr == `MIO_OFS_OUT) begin
                gpo_reg <= pwdata[9:0];
            end
            if (wr_en && paddr == `MIO_OFS_MASK) begin
                mask_reg <= pwdata[`MIO_ST_W-1:0];
            end
            if (brk_wr && cmd == `MIO_BRK_ON) begin
                brake_en_reg <= 1'b1;
            end else if (brk_wr && cmd == `MIO_BRK_OFF) begin
                brake_en_reg <= 1'b0;
            end
        end
    end

    // ================================================================
    // Events and sticky status
    mio_edge u_e_pl (.pclk(pclk), .presetn(presetn),
        .din(pin_in[2]), .rise(rises[0]));
    mio_edge u_e_nl (.pclk(pclk), .presetn(presetn),
        .din(pin_in[3]), .rise(rises[1]));
    mio_edge u_e_i4 (.pclk(pclk), .presetn(presetn),
        .din(pin_in[4]), .rise(rises[2]));
    mio_edge u_e_i5 (.pclk(pclk), .presetn(presetn),
        .din(pin_in[5]), .rise(rises[3]));
    mio_edge u_e_go (.pclk(pclk), .presetn(presetn),
        .din(pin_in[6]), .rise(rises[4]));

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_prev_reg <= 1'b0;
        end else begin
            en_prev_reg <= pin_in[7];
        end
    end
    assign en_fall = en_prev_reg & ~pin_in[7];

    always @* begin
        stat_set = {`MIO_ST_W{1'b0}};
        stat_set[`MIO_ST_PLIM]   = func_reg[`MIO_F_PLIM] & pin_in[2];
        stat_set[`MIO_ST_NLIM]   = func_reg[`MIO_F_NLIM] & pin_in[3];
        stat_set[`MIO_ST_ENLOST] = en_fall;
        stat_set[`MIO_ST_BADCMD] = brk_wr & (cmd != `MIO_BRK_ON)
                                   & (cmd != `MIO_BRK_OFF);
        stat_set[`MIO_ST_IDX4]   = func_reg[`MIO_F_IDX4] & rises[2];
        stat_set[`MIO_ST_IDX5]   = func_reg[`MIO_F_IDX5] & rises[3];
        stat_set[`MIO_ST_NETERR] = net_error;
        stat_set[`MIO_ST_GO]     = func_reg[`MIO_F_GO6] & rises[4];
        stat_clr = {`MIO_ST_W{1'b0}};
        if (wr_en && paddr == `MIO_OFS_STAT) begin
            stat_clr = pwdata[`MIO_ST_W-1:0];
        end
        if (cmd_wr && cmd == `MIO_CMD_GENW0) begin
            stat_clr = stat_clr | {`MIO_ST_W{1'b1}};
            stat_set[`MIO_ST_PLIM] = 1'b0;
            stat_set[`MIO_ST_NLIM] = 1'b0;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < `MIO_ST_W; gi = gi + 1) begin : g_st
            mio_sticky u_st (.pclk(pclk), .presetn(presetn),
                .set(stat_set[gi]), .clr(stat_clr[gi]), .q(stat[gi]));
        end
    endgenerate

    // ================================================================
    // Read mux
    always @* begin
        rdata_next = 32'h00000000;
        err_next   = 1'b0;
        case (paddr)
            `MIO_OFS_FUNC:  rdata_next[`MIO_FUNC_W-1:0] = func_reg;
            `MIO_OFS_OUT:   rdata_next[9:0] = gpo_reg;
            `MIO_OFS_IN:    rdata_next[9:0] = pin_in;
            `MIO_OFS_STAT:  rdata_next[`MIO_ST_W-1:0] = stat;
            `MIO_OFS_MASK:  rdata_next[`MIO_ST_W-1:0] = mask_reg;
            `MIO_OFS_CMD:   rdata_next = 32'h00000000;
            `MIO_OFS_BRAKE: rdata_next[7:0] =
                brake_en_reg ? `MIO_BRK_ON : `MIO_BRK_OFF;
            `MIO_OFS_INWORD: rdata_next[3:0] = pin_in[3:0] & `MIO_LOWMASK;
            `MIO_OFS_CTRL:  rdata_next[0] = bidir_ok;
            default:        err_next = 1'b1;
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h00000000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & err_next;
            if (psel && !penable && !pwrite) begin
                prdata <= rdata_next;
            end
        end
    end

    // ================================================================
    // Pin drive and function outputs
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_out        <= 10'h000;
            pin_oe         <= 10'h000;
            motion_allowed <= 1'b0;
            limit_pos      <= 1'b0;
            limit_neg      <= 1'b0;
            index_ext      <= 1'b0;
            index_int      <= 1'b0;
            go_trigger     <= 1'b0;
            home_input     <= 1'b0;
            analog_sel     <= 2'h0;
            irq            <= 1'b0;
        end else begin
            pin_out[7:0] <= 8'h00;
            pin_oe[3:0]  <= 4'h0;
            pin_oe[7:6]  <= 2'h0;
            // bidir point 4 only if fitted
            pin_oe[4]  <= bidir_ok & ~func_reg[`MIO_F_IDX4];
            pin_out[4] <= bidir_ok & ~func_reg[`MIO_F_IDX4] & gpo_reg[4];
            // bidir point 5 only if fitted
            pin_oe[5]  <= bidir_ok & ~func_reg[`MIO_F_IDX5];
            pin_out[5] <= bidir_ok & ~func_reg[`MIO_F_IDX5] & gpo_reg[5];
            pin_oe[8]  <= 1'b1;
            pin_out[8] <= brake_en_reg ? brake_request : gpo_reg[8];
            pin_oe[9]  <= 1'b1;
            pin_out[9] <= func_reg[`MIO_F_NFLT9] ? gpo_reg[9] :
                          ~fault_active;
            motion_allowed <= pin_in[7];
            limit_pos  <= func_reg[`MIO_F_PLIM] & pin_in[2];
            limit_neg  <= func_reg[`MIO_F_NLIM] & pin_in[3];
            index_ext  <= func_reg[`MIO_F_IDX4] & rises[2];
            index_int  <= func_reg[`MIO_F_IDX5] & rises[3];
            go_trigger <= func_reg[`MIO_F_GO6] & rises[4];
            home_input <= func_reg[`MIO_F_HOME6] & ~func_reg[`MIO_F_GO6]
                          & pin_in[6];
            analog_sel <= {func_reg[`MIO_F_AN1], func_reg[`MIO_F_AN0]};
            irq <= |(stat & mask_reg);
        end
    end
endmodule

// ### testbench/mio_top_sva.sv
// Checker for the motion I/O block, bound onto its top module.
// Assumes one clock, pclk, and asynchronous active-low presetn.
`timescale 1ns/1ns
module mio_chk (
    input logic       pclk,
    input logic       presetn,
    input logic       psel,
    input logic       penable,
    input logic       pready,
    input logic [9:0] pin_in,
    input logic       bidir_present,
    input logic [9:0] pin_oe,
    input logic       motion_allowed,
    input logic       limit_pos,
    input logic       limit_neg,
    input logic       index_ext,
    input logic       index_int,
    input logic       go_trigger,
    input logic       home_input
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ======================================
    // Pin directions
    a_oe_inonly: assert property (
        pin_oe[3:0] == 4'h0 && pin_oe[7:6] == 2'h0) else $error("input driven");
    a_oe_outonly: assert property (
        $past(presetn) |-> pin_oe[9:8] == 2'h3) else $error("output not driven");
    a_oe_bidir: assert property (
        |pin_oe[5:4] |-> $past(bidir_present)) else $error("bidir driven");
    // ======================================
    // Special functions and APB ready
    a_drive_gate: assert property (
        motion_allowed |-> $past(pin_in[7])) else $error("motion unenabled");
    a_lim_pos: assert property (
        limit_pos |-> $past(pin_in[2])) else $error("pos limit unsourced");
    a_lim_neg: assert property (
        limit_neg |-> $past(pin_in[3])) else $error("neg limit unsourced");
    a_idx_ext: assert property (
        index_ext |=> !index_ext) else $error("index ext too long");
    a_idx_int: assert property (
        index_int |=> !index_int) else $error("index int too long");
    a_go_home: assert property (
        !(go_trigger && home_input)) else $error("go and home together");
    a_apb_ready: assert property (
        psel && penable |-> pready ##1 !pready) else $error("bad pready");
endmodule
bind mio_top mio_chk u_chk (.pclk, .presetn, .psel, .penable, .pready,
    .pin_in, .bidir_present, .pin_oe, .motion_allowed, .limit_pos,
    .limit_neg, .index_ext, .index_int, .go_trigger, .home_input);

// ### testbench/mio_pins.sv
// Far-side model: switches and sensors give levels set by the bench.
// Assumes the block reads pin_in synchronous to pclk.
`timescale 1ns/1ns
module mio_pins (
    input  logic       pclk,
    input  logic [9:0] want,
    input  logic [9:0] pin_out,
    input  logic [9:0] pin_oe,
    output logic [9:0] pin_in
);
    // ======================================
    // Follower side of the encoder output
    // follower scales for 4096 counts
    // A follower must use 4096 counts per turn instead of 4000
    // and reverse its direction; no encoder output leaves this block
    localparam int FOLLOW_COUNTS = 4096;
    localparam int NATIVE_COUNTS = 4000;
    // ======================================
    // Wire level
    // driven pin wins
    // One flop keeps the level synchronous, as the block expects
    always @(posedge pclk) begin
        pin_in <= (want & ~pin_oe) | (pin_out & pin_oe);
    end
endmodule

// ### testbench/test_mio_top.sv
// Self-checking bench for the motion I/O block over APB.
// Assumes mio_defs.vh on the include path and the pin model.
`timescale 1ns/1ns
`include "mio_defs.vh"
module test_mio_top;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [9:0]  want, pin_in, pin_out, pin_oe;
    logic        bidir_present, net_error, fault_active, brake_request;
    logic        motion_allowed, limit_pos, limit_neg, index_ext;
    logic        index_int, go_trigger, home_input, irq, err;
    logic [1:0]  analog_sel;
    int          n_errors, total_checks;
    localparam logic [31:0] ALL = 32'hFFFF_FFFF;

    mio_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .pin_in, .bidir_present,
        .net_error, .fault_active, .brake_request, .pin_out, .pin_oe,
        .motion_allowed, .limit_pos, .limit_neg, .index_ext, .index_int,
        .go_trigger, .home_input, .analog_sel, .irq);
    mio_pins u_pins (.pclk, .want, .pin_out, .pin_oe, .pin_in);

    initial begin
        pclk = 1'h0;
        forever #25 pclk = ~pclk;
    end
    // ======================================
    // Bus and check tasks
    task automatic apb(input [11:0] a, input w, input [31:0] d);
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        @(posedge pclk);
        while (pready !== 1'h1) @(posedge pclk);
        r = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic wr(input [11:0] a, input [31:0] d);
        apb(a, 1'h1, d);
    endtask
    task automatic chk(input [31:0] s, input [31:0] e);
        total_checks++;
        if (s !== e) begin
            n_errors++;
            $display("FAIL at %0t: saw %h want %h", $time, s, e);
        end
    endtask
    task automatic rc(input [11:0] a, input [31:0] m, input [31:0] e);
        apb(a, 1'h0, 32'h0);
        chk(r & m, e);
    endtask
    // Outputs lag a register change by one cycle; pins add one more
    task automatic st;
        repeat (4) @(posedge pclk);
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // ======================================
    // Tests
    initial begin
        presetn = 1'h0;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        want = 10'h080;
        bidir_present = 1'h0;
        net_error = 1'h0;
        fault_active = 1'h0;
        brake_request = 1'h0;
        repeat (10) @(posedge pclk);
        presetn <= 1'h1;
        st;
        rc(`MIO_OFS_FUNC, ALL, 32'h00C);
        rc(`MIO_OFS_BRAKE, ALL, 32'h08);
        rc(`MIO_OFS_STAT, ALL, 32'h0);
        rc(`MIO_OFS_OUT, ALL, 32'h0);
        chk(pin_oe, 10'h300);
        chk(pin_out[9], 1'h1);
        apb(12'h100, 1'h0, 32'h0);
        chk(err, 1'h1);
        chk(r, 32'h0);
        $display("test reset done");
        for (int i = 0; i < 16; i++) begin
            want <= 10'h080 | i[9:0];
            st;
            rc(`MIO_OFS_INWORD, ALL, i);
        end
        $display("test word read done");
        want <= 10'h08C;
        st;
        chk(limit_pos, 1'h1);
        chk(limit_neg, 1'h1);
        rc(`MIO_OFS_STAT, 32'h3, 32'h3);
        wr(`MIO_OFS_CMD, `MIO_CMD_GEN2);
        st;
        chk(limit_pos, 1'h0);
        rc(`MIO_OFS_FUNC, 32'hC, 32'h8);
        wr(`MIO_OFS_STAT, 32'h1);
        rc(`MIO_OFS_STAT, 32'h1, 32'h0);
        wr(`MIO_OFS_CMD, `MIO_CMD_GEN3);
        wr(`MIO_OFS_CMD, `MIO_CMD_RESTP);
        st;
        chk(limit_neg, 1'h0);
        chk(limit_pos, 1'h1);
        rc(`MIO_OFS_FUNC, 32'hC, 32'h4);
        wr(`MIO_OFS_FUNC, 32'h1FF);
        st;
        chk(analog_sel, 2'h3);
        wr(`MIO_OFS_CMD, `MIO_CMD_GENW0);
        st;
        rc(`MIO_OFS_FUNC, ALL, 32'h0);
        rc(`MIO_OFS_STAT, ALL, 32'h0);
        chk({analog_sel, limit_pos}, 3'h0);
        $display("test limits done");
        brake_request <= 1'h1;
        st;
        chk(pin_out[8], 1'h1);
        brake_request <= 1'h0;
        wr(`MIO_OFS_BRAKE, 32'h05);
        rc(`MIO_OFS_BRAKE, ALL, 32'h08);
        rc(`MIO_OFS_STAT, 32'h8, 32'h8);
        wr(`MIO_OFS_OUT, 32'h100);
        st;
        chk(pin_out[8], 1'h0);
        wr(`MIO_OFS_BRAKE, `MIO_BRK_OFF);
        st;
        rc(`MIO_OFS_BRAKE, ALL, 32'hFF);
        chk(pin_out[8], 1'h1);
        wr(`MIO_OFS_BRAKE, `MIO_BRK_ON);
        st;
        chk(pin_out[8], 1'h0);
        fault_active <= 1'h1;
        st;
        chk(pin_out[9], 1'h0);
        wr(`MIO_OFS_FUNC, 32'h100);
        wr(`MIO_OFS_OUT, 32'h200);
        st;
        chk(pin_out[9], 1'h1);
        $display("test outputs done");
        wr(`MIO_OFS_OUT, 32'h03F);
        st;
        chk(pin_oe[5:0], 6'h00);
        bidir_present <= 1'h1;
        st;
        chk(pin_oe[5:4], 2'h3);
        chk(pin_out[5:4], 2'h3);
        chk(pin_oe[3:0], 4'h0);
        rc(`MIO_OFS_CTRL, 32'h1, 32'h1);
        wr(`MIO_OFS_OUT, 32'h0);
        wr(`MIO_OFS_STAT, 32'hFF);
        wr(`MIO_OFS_FUNC, 32'h0F0);
        want <= 10'h0F0;
        st;
        rc(`MIO_OFS_STAT, 32'hB0, 32'hB0);
        chk(home_input, 1'h0);
        wr(`MIO_OFS_FUNC, 32'h080);
        st;
        chk(home_input, 1'h1);
        $display("test special inputs done");
        wr(`MIO_OFS_STAT, 32'hFF);
        wr(`MIO_OFS_MASK, 32'h40);
        net_error <= 1'h1;
        st;
        net_error <= 1'h0;
        rc(`MIO_OFS_STAT, 32'h40, 32'h40);
        chk(irq, 1'h1);
        wr(`MIO_OFS_MASK, 32'h0);
        st;
        chk(irq, 1'h0);
        wr(`MIO_OFS_MASK, 32'h40);
        wr(`MIO_OFS_STAT, 32'h40);
        st;
        chk(irq, 1'h0);
        want <= 10'h000;
        st;
        chk(motion_allowed, 1'h0);
        rc(`MIO_OFS_STAT, 32'h4, 32'h4);
        want <= 10'h080;
        st;
        chk(motion_allowed, 1'h1);
        $display("test irq and enable done");
        wrap_up;
    end
    // A hang in a bus wait ends here instead of running forever
    initial begin
        repeat (5000) @(posedge pclk);
        n_errors++;
        wrap_up;
    end
endmodule
